/* design/acs_consts.svh */
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define ACS_OFF_CTRL_A 8'h00
`define ACS_OFF_CTRL_B 8'h04
`define ACS_OFF_INPUT_SEL 8'h08
`define ACS_OFF_RESULT_LOW 8'h0c
`define ACS_OFF_RESULT_HIGH 8'h10

// ********************************************************************
// Field positions
// ********************************************************************
`define ACS_A_ENABLE 7
`define ACS_A_START 6
`define ACS_A_AUTO 5
`define ACS_A_FLAG 4
`define ACS_A_PSEL_LSB 0
`define ACS_B_LEFT 4
`define ACS_B_TSEL_LSB 0
`define ACS_S_CHAN_LSB 0
`define ACS_S_REF_LSB 6

// ********************************************************************
// Reset values
// ********************************************************************
`define ACS_RST_PSEL 3'h0
`define ACS_RST_TSEL 3'h0
`define ACS_RST_CHAN 3'h0
`define ACS_RST_REF 2'h0
`define ACS_RST_RESULT 10'h000

// ********************************************************************
// Timing, in converter clock cycles, counted in half cycles, and the free running trigger source
// ********************************************************************
`define ACS_SH_FIRST_X2 6'd27
`define ACS_DONE_FIRST_X2 6'd50
`define ACS_SH_NORMAL_X2 6'd3
`define ACS_DONE_NORMAL_X2 6'd26
`define ACS_SH_AUTO_X2 6'd4
`define ACS_DONE_AUTO_X2 6'd27
`define ACS_SH_FREE_X2 6'd5
`define ACS_DONE_FREE_X2 6'd28
`define ACS_FREE_RUN_SRC 3'h0

`endif

/* design/acs_pkg.sv */
package acs_pkg;
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_WAIT = 2'b01,
        ACS_CONV = 2'b11
    } acs_state_t;

    typedef enum logic [1:0] {
        ACS_M_NORMAL = 2'b00,
        ACS_M_AUTO = 2'b01,
        ACS_M_FREE = 2'b11,
        ACS_M_FIRST = 2'b10
    } acs_mode_t;
endpackage

/* design/acs_trig_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_trig_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous levels in, synchronised levels out
    input wire logic [6:0] async_in,
    output logic [6:0] sync_out
);
    logic [6:0] meta_r;

    genvar i;
    generate
        for (i = 0; i < 7; i = i + 1) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_r[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_r[i] <= async_in[i];
                    sync_out[i] <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* design/acs_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_prescaler (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    input wire logic restart,
    input wire logic [2:0] ratio_sel,
    // Converter clock edges as one-cycle enables, and the divider count
    output logic rise_tick,
    output logic half_tick,
    output logic [6:0] count
);
    logic [7:0] ratio;
    logic [6:0] last;
    logic [6:0] mid;

    // Select 0 and 1 both divide by two.
    assign ratio = (ratio_sel == 3'h0) ? 8'h02 : (8'h01 << ratio_sel);
    assign last = 7'(ratio - 8'h01);
    assign mid = 7'((ratio >> 1) - 8'h01);
    assign rise_tick = run && (count == last);
    assign half_tick = run && ((count == last) || (count == mid));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 7'h00;
        end else if (!run || restart || count >= last) begin
            count <= 7'h00;
        end else begin
            count <= count + 7'h01;
        end
    end
endmodule
`default_nettype wire

/* design/acs_sequencer.sv */
// Function
// [RL1] Software clears power reduction before converting
// [RL2] Start bit launches conversion, clears when done
// [RL3] Channel change waits for running conversion
// [RL4] Auto trigger edge restarts prescaler, starts conversion
// [RL5] Held trigger or edges during conversion ignored
// [RL6] Source flag must clear before next trigger
// [RL7] Free running restarts on own completion
// [RL8] Start bit reads one during any conversion
// [RL9] Prescaler runs with enable, reset otherwise
// [RL10] Converter clock is divided system clock
// [RL11] Software start begins at next converter edge
// [RL12] Conversion lasts 13 cycles, first 25
// [RL13] Sample at 1.5 cycles, first at 13.5
// [RL14] Completion writes result, sets flag, clears start
// [RL15] Auto conversion samples at 2, takes 13.5
// [RL16] Free running samples 2.5, takes 14
// [RL17] Selection buffered, locked during conversion
// [RL18] Selection follows again in last cycle
// [RL19] Software waits a cycle before reselecting
// [RL20] Software reselects only in safe periods
// [RL21] Free running next conversion keeps old channel
// [RL22] Software discards first result after reference switch
// [RL23] Software keeps converter clock in range
// [RL24] Low byte read blocks result update
// [RL25] Result right adjusted, or left when selected
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`include "acs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power gate and trigger sources
    input wire logic conv_power_reduce,
    input wire logic [6:0] trig_in,
    // Analogue converter side
    input wire logic [9:0] sar_result,
    output logic sample_hold,
    output logic conv_active,
    output logic [2:0] channel_select,
    output logic [1:0] reference_select
);
    import acs_pkg::*;

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    logic conv_enable_r;
    logic conv_start_bit_r;
    logic auto_trigger_enable_r;
    logic conv_complete_flag_r;
    logic [2:0] prescaler_select_r;
    logic left_adjust_r;
    logic [2:0] trigger_source_select_r;
    logic [2:0] chan_temp_r;
    logic [1:0] ref_temp_r;
    logic [9:0] result_r;
    logic result_lock_r;
    logic first_pending_r;
    acs_state_t state_r;
    acs_mode_t mode_r;
    logic [5:0] half_cnt_r;
    logic [6:0] trig_prev_r;

    logic [6:0] trig_sync;
    logic rise_tick;
    logic half_tick;
    logic [6:0] presc_count;
    logic wr_en;
    logic rd_en;
    logic trig_edge;
    logic sw_go;
    logic done;
    logic free_mode;
    logic locked;
    logic [5:0] sh_point;
    logic [5:0] done_point;
    logic may_run;

    acs_trig_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(trig_in),
        .sync_out(trig_sync)
    );

    acs_prescaler u_presc (
        .pclk(pclk),
        .presetn(presetn),
        .run(conv_enable_r),
        .restart(trig_edge),
        .ratio_sel(prescaler_select_r),
        .rise_tick(rise_tick),
        .half_tick(half_tick),
        .count(presc_count)
    );

    // ****************************************************************
    // Start and completion decode
    // ****************************************************************
    // Power reduction gates every start; keeping it clear is software's job.
    assign may_run = conv_enable_r && !conv_power_reduce; // [RL1]
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && penable && pready && !pwrite;
    assign free_mode = auto_trigger_enable_r &&
                       (trigger_source_select_r == `ACS_FREE_RUN_SRC);
    // Only a fresh rising edge counts, and only while idle, so a level still
    // high at completion, or an edge mid-conversion, starts nothing.
    assign trig_edge = may_run && auto_trigger_enable_r && !free_mode &&
        state_r == ACS_IDLE &&
        trig_sync[trigger_source_select_r - 3'h1] &&
        !trig_prev_r[trigger_source_select_r - 3'h1]; // [RL4] [RL5] [RL6]
    assign sw_go = state_r == ACS_WAIT && rise_tick; // [RL11]
    always_comb begin
        case (mode_r)
            ACS_M_FIRST: begin
                sh_point = `ACS_SH_FIRST_X2; // [RL13]
                done_point = `ACS_DONE_FIRST_X2; // [RL12]
            end
            ACS_M_AUTO: begin
                sh_point = `ACS_SH_AUTO_X2; // [RL15]
                done_point = `ACS_DONE_AUTO_X2;
            end
            ACS_M_FREE: begin
                sh_point = `ACS_SH_FREE_X2; // [RL16]
                done_point = `ACS_DONE_FREE_X2;
            end
            default: begin
                sh_point = `ACS_SH_NORMAL_X2; // [RL13]
                done_point = `ACS_DONE_NORMAL_X2; // [RL12]
            end
        endcase
    end
    assign done = state_r == ACS_CONV && half_tick &&
                  half_cnt_r == done_point - 6'd1;
    // The lock drops for the last converter cycle of the conversion.
    assign locked = state_r == ACS_CONV &&
                    half_cnt_r < done_point - 6'd2; // [RL17] [RL18]

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ACS_IDLE;
            mode_r <= ACS_M_NORMAL;
            half_cnt_r <= 6'd0;
        end else if (!may_run) begin
            state_r <= ACS_IDLE;
            half_cnt_r <= 6'd0;
        end else begin
            case (state_r)
                ACS_IDLE: begin
                    half_cnt_r <= 6'd0;
                    if (trig_edge) begin
                        state_r <= ACS_CONV; // [RL4]
                        mode_r <= first_pending_r ? ACS_M_FIRST : ACS_M_AUTO;
                    end else if (conv_start_bit_r) begin
                        state_r <= ACS_WAIT;
                    end
                end
                ACS_WAIT: begin
                    if (sw_go) begin
                        state_r <= ACS_CONV; // [RL11]
                        mode_r <= first_pending_r ? ACS_M_FIRST : ACS_M_NORMAL;
                    end
                end
                ACS_CONV: begin
                    if (done && free_mode) begin
                        half_cnt_r <= 6'd0; // [RL7] [RL16]
                        mode_r <= ACS_M_FREE;
                    end else if (done) begin
                        state_r <= ACS_IDLE;
                        half_cnt_r <= 6'd0;
                    end else if (half_tick) begin
                        half_cnt_r <= half_cnt_r + 6'd1; // [RL12]
                    end
                end
                default: begin
                    state_r <= ACS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_pending_r <= 1'b1;
        end else if (!conv_enable_r) begin
            first_pending_r <= 1'b1;
        end else if (state_r == ACS_CONV) begin
            first_pending_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_r <= 7'h00;
        end else begin
            trig_prev_r <= trig_sync;
        end
    end

    // ****************************************************************
    // Analogue side outputs
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_hold <= 1'b0;
            conv_active <= 1'b0;
            channel_select <= `ACS_RST_CHAN;
            reference_select <= `ACS_RST_REF;
        end else begin
            sample_hold <= state_r == ACS_CONV && half_tick &&
                           half_cnt_r == sh_point - 6'd1; // [RL13]
            conv_active <= state_r == ACS_CONV;
            // Free running restart keeps the lock, so the next conversion
            // uses whatever was latched in the last cycle.
            if (!locked && conv_enable_r) begin
                channel_select <= chan_temp_r; // [RL3] [RL17] [RL21]
                reference_select <= ref_temp_r;
            end
        end
    end

    // ****************************************************************
    // Control and status bits
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_enable_r <= 1'b0;
            auto_trigger_enable_r <= 1'b0;
            prescaler_select_r <= `ACS_RST_PSEL;
            left_adjust_r <= 1'b0;
            trigger_source_select_r <= `ACS_RST_TSEL;
            chan_temp_r <= `ACS_RST_CHAN;
            ref_temp_r <= `ACS_RST_REF;
        end else if (wr_en) begin
            case (paddr)
                `ACS_OFF_CTRL_A: begin
                    conv_enable_r <= pwdata[`ACS_A_ENABLE]; // [RL9]
                    auto_trigger_enable_r <= pwdata[`ACS_A_AUTO];
                    prescaler_select_r <=
                        pwdata[`ACS_A_PSEL_LSB +: 3]; // [RL10]
                end
                `ACS_OFF_CTRL_B: begin
                    left_adjust_r <= pwdata[`ACS_B_LEFT];
                    trigger_source_select_r <= pwdata[`ACS_B_TSEL_LSB +: 3];
                end
                `ACS_OFF_INPUT_SEL: begin
                    chan_temp_r <= pwdata[`ACS_S_CHAN_LSB +: 3];
                    ref_temp_r <= pwdata[`ACS_S_REF_LSB +: 2];
                end
                default: begin
                end
            endcase
        end
    end

    // The start bit is also held through a conversion that a trigger began.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_start_bit_r <= 1'b0;
        end else if (!may_run) begin
            conv_start_bit_r <= 1'b0;
        end else if (done && !free_mode) begin
            conv_start_bit_r <= 1'b0; // [RL2] [RL14]
        end else if (trig_edge) begin
            conv_start_bit_r <= 1'b1; // [RL8]
        end else if (wr_en && paddr == `ACS_OFF_CTRL_A &&
                     pwdata[`ACS_A_START]) begin
            conv_start_bit_r <= 1'b1; // [RL2]
        end
    end

    // Set beats a clear written in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_complete_flag_r <= 1'b0;
        end else if (done) begin
            conv_complete_flag_r <= 1'b1; // [RL14] [RL24]
        end else if (wr_en && paddr == `ACS_OFF_CTRL_A &&
                     pwdata[`ACS_A_FLAG]) begin
            conv_complete_flag_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Result and its read lock
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_r <= `ACS_RST_RESULT;
        end else if (done && !result_lock_r) begin
            result_r <= sar_result; // [RL14] [RL24]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_lock_r <= 1'b0;
        end else if (rd_en && paddr == `ACS_OFF_RESULT_HIGH) begin
            result_lock_r <= 1'b0;
        end else if (rd_en && paddr == `ACS_OFF_RESULT_LOW) begin
            result_lock_r <= 1'b1; // [RL24]
        end
    end

    // ****************************************************************
    // APB read path, no wait states
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    `ACS_OFF_CTRL_A: begin
                        prdata[`ACS_A_ENABLE] <= conv_enable_r;
                        prdata[`ACS_A_START] <= conv_start_bit_r; // [RL8]
                        prdata[`ACS_A_AUTO] <= auto_trigger_enable_r;
                        prdata[`ACS_A_FLAG] <= conv_complete_flag_r;
                        prdata[`ACS_A_PSEL_LSB +: 3] <= prescaler_select_r;
                    end
                    `ACS_OFF_CTRL_B: begin
                        prdata[`ACS_B_LEFT] <= left_adjust_r;
                        prdata[`ACS_B_TSEL_LSB +: 3] <=
                            trigger_source_select_r;
                    end
                    `ACS_OFF_INPUT_SEL: begin
                        prdata[`ACS_S_CHAN_LSB +: 3] <= chan_temp_r;
                        prdata[`ACS_S_REF_LSB +: 2] <= ref_temp_r;
                    end
                    `ACS_OFF_RESULT_LOW: begin
                        prdata[7:0] <= left_adjust_r ?
                            {result_r[1:0], 6'h00} : result_r[7:0]; // [RL25]
                    end
                    `ACS_OFF_RESULT_HIGH: begin
                        prdata[7:0] <= left_adjust_r ?
                            result_r[9:2] : {6'h00, result_r[9:8]}; // [RL25]
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    start_reads_one_a: assert property ( // [RL8]
        @(posedge pclk) disable iff (!presetn)
        state_r == ACS_CONV |-> conv_start_bit_r)
        else $error("start bit low during conversion");

    start_clears_a: assert property ( // [RL2]
        @(posedge pclk) disable iff (!presetn)
        (done && !free_mode && may_run) |=> !conv_start_bit_r)
        else $error("start bit not cleared at completion");

    sel_locked_a: assert property ( // [RL3]
        @(posedge pclk) disable iff (!presetn)
        locked && $past(locked) |-> $stable(channel_select))
        else $error("channel changed while locked");

    trig_starts_a: assert property ( // [RL4]
        @(posedge pclk) disable iff (!presetn)
        trig_edge |=> state_r == ACS_CONV && presc_count == 7'h00)
        else $error("trigger edge did not start conversion");

    no_edge_busy_a: assert property ( // [RL5]
        @(posedge pclk) disable iff (!presetn)
        state_r == ACS_IDLE && trig_prev_r == trig_sync |=>
        state_r != ACS_CONV)
        else $error("held trigger started a conversion");

    presc_held_a: assert property ( // [RL9]
        @(posedge pclk) disable iff (!presetn)
        !conv_enable_r ##1 !conv_enable_r |-> presc_count == 7'h00)
        else $error("prescaler ran while disabled");

    free_restart_a: assert property ( // [RL7]
        @(posedge pclk) disable iff (!presetn)
        (done && free_mode && may_run) |=> state_r == ACS_CONV &&
        half_cnt_r == 6'd0 && conv_start_bit_r)
        else $error("free running did not restart");

    flag_sets_a: assert property ( // [RL14]
        @(posedge pclk) disable iff (!presetn)
        done |=> conv_complete_flag_r)
        else $error("completion flag not set");

    result_kept_a: assert property ( // [RL24]
        @(posedge pclk) disable iff (!presetn)
        done && result_lock_r |=> $stable(result_r))
        else $error("result updated while locked");

    sample_first_a: assert property ( // [RL13]
        @(posedge pclk) disable iff (!presetn)
        sample_hold && $past(mode_r) == ACS_M_FIRST |->
        $past(half_cnt_r) == 6'd26)
        else $error("first sample at wrong time");
endmodule
`default_nettype wire

/* test/acs_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Trigger source and converter result model
// ****************************************************************
module acs_partner (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Requests from the bench
    input wire logic trig_req,
    input wire logic [9:0] value,
    // Converter side
    input wire logic conv_active,
    output logic [6:0] trig_in,
    output logic [9:0] sar_result
);
    logic tgl_r;

    // The source flag stays up until the bench drops it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgl_r <= 1'b0;
            trig_in <= 7'h00;
        end else begin
            tgl_r <= ~tgl_r;
            trig_in <= {6'h00, trig_req};
        end
    end

    // Outside a conversion the result lines carry junk that changes.
    assign sar_result = conv_active ? value : (tgl_r ? ~value : value);
endmodule
`default_nettype wire

/* test/adc_conversion_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.svh"
module adc_conversion_sequencer_test;
    import acs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, conv_power_reduce;
    logic pready, pslverr, sample_hold, conv_active, serr, trig_req;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [6:0] trig_in;
    logic [9:0] sar_result, val;
    logic [2:0] channel_select;
    logic [1:0] reference_select;
    int err_count, tests_run, cyc, n, t0;

    acs_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_power_reduce(conv_power_reduce),
        .trig_in(trig_in), .sar_result(sar_result),
        .sample_hold(sample_hold), .conv_active(conv_active),
        .channel_select(channel_select),
        .reference_select(reference_select));
    acs_partner far (.pclk(pclk), .presetn(presetn), .trig_req(trig_req),
        .value(val), .conv_active(conv_active), .trig_in(trig_in),
        .sar_result(sar_result));

    // ****************************************************************
    // Reference model and helpers
    // ****************************************************************
    function automatic logic [31:0] model(input int r, input bit hi,
                                          input bit left);
        if (left) begin
            return hi ? (r >> 2) & 32'hff : (r & 32'h3) << 6;
        end
        return hi ? (r >> 8) & 32'h3 : r & 32'hff;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int g;
        g = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            g++;
        end while (pready !== 1'b1 && g < 50);
        if (pready !== 1'b1) begin
            err_count++;
            give_verdict();
        end
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_end(output int len);
        int w;
        len = 0;
        w = 0;
        while (conv_active !== 1'b1 && w < 200) begin
            @(posedge pclk);
            w++;
        end
        while (conv_active === 1'b1 && len < 200) begin
            @(posedge pclk);
            len++;
        end
        if (w >= 200 || len >= 200) begin
            err_count++;
            give_verdict();
        end
    endtask

    task automatic wait_sh(output int len);
        len = 0;
        do begin
            @(posedge pclk);
            len++;
        end while (sample_hold !== 1'b1 && len < 400);
        if (sample_hold !== 1'b1) begin
            err_count++;
            give_verdict();
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {presetn, psel, penable, pwrite, trig_req} = 5'h00;
        conv_power_reduce = 1'b0; // Power stays on until the final power reduction check.
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(52740));
        val = $urandom & 32'h3ff;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h20, 0);
        check(serr, 1);
        apb(1'b0, `ACS_OFF_CTRL_A, 0);
        check(q, 0);
        // Divide by two keeps the run short, far above the clean range.
        apb(1'b1, `ACS_OFF_CTRL_A, 32'h80);
        apb(1'b1, `ACS_OFF_CTRL_A, 32'hc0);
        apb(1'b0, `ACS_OFF_CTRL_A, 0);
        check(q[6], 1);
        apb(1'b1, `ACS_OFF_INPUT_SEL, 32'h85);
        check(channel_select, 0);
        wait_end(n);
        check(channel_select, 5);
        check(reference_select, 2);
        apb(1'b0, `ACS_OFF_CTRL_A, 0);
        check(q[6:4], 3'b001);
        apb(1'b0, `ACS_OFF_RESULT_LOW, 0);
        check(q, model(val, 0, 0));
        apb(1'b0, `ACS_OFF_RESULT_HIGH, 0);
        check(q, model(val, 1, 0));
        // First result on the new reference is never read.
        apb(1'b1, `ACS_OFF_CTRL_A, 32'hc0);
        wait_end(n);
        check(n >= 24 && n <= 30, 1);
        // Divide by four doubles the conversion length.
        apb(1'b1, `ACS_OFF_CTRL_A, 32'hc2);
        wait_end(n);
        check(n >= 50 && n <= 56, 1);
        apb(1'b1, `ACS_OFF_CTRL_B, 32'h10);
        val = $urandom & 32'h3ff;
        apb(1'b1, `ACS_OFF_CTRL_A, 32'hd0);
        wait_end(n);
        apb(1'b0, `ACS_OFF_RESULT_LOW, 0);
        check(q, model(val, 0, 1));
        apb(1'b1, `ACS_OFF_CTRL_B, 32'h00);
        apb(1'b1, `ACS_OFF_CTRL_A, 32'hd0);
        t0 = val;
        val = ~val;
        wait_end(n);
        apb(1'b0, `ACS_OFF_RESULT_HIGH, 0);
        check(q, model(t0, 1, 0));
        apb(1'b0, `ACS_OFF_CTRL_A, 0);
        check(q[4], 1);
        apb(1'b1, `ACS_OFF_CTRL_B, 32'h01);
        apb(1'b1, `ACS_OFF_CTRL_A, 32'hb0);
        trig_req <= 1'b1;
        wait_sh(n);
        check(n >= 5 && n <= 10, 1);
        wait_end(n);
        n = 0;
        repeat (80) begin
            @(posedge pclk);
            n += conv_active;
        end
        check(n, 0);
        trig_req <= 1'b0;
        apb(1'b1, `ACS_OFF_CTRL_B, 32'h00);
        apb(1'b1, `ACS_OFF_CTRL_A, 32'he0);
        repeat (2) wait_sh(n);
        wait_sh(n);
        check(n, 28);
        apb(1'b0, `ACS_OFF_CTRL_A, 0);
        check(q[6], 1);
        apb(1'b1, `ACS_OFF_CTRL_A, 32'h00);
        repeat (4) @(posedge pclk);
        check(conv_active, 0);
        apb(1'b0, `ACS_OFF_CTRL_A, 0);
        check(q[7:6], 0);
        conv_power_reduce <= 1'b1;
        apb(1'b1, `ACS_OFF_CTRL_A, 32'hc0);
        repeat (40) @(posedge pclk);
        check(conv_active, 0);
        apb(1'b0, `ACS_OFF_CTRL_A, 0);
        check(q[6], 0);
        give_verdict();
    end
endmodule
`default_nettype wire
